// file: usart_consts.svh
// constants of the usart clock generation and frame logic
// Operation
// (R01) four clock modes, sync select bit
// (R02) pin direction picks master or slave clock
// (R03) clock pin used only in sync mode
// (R04) divisor counter reloads at zero, low write
// (R05) tick at zero: clock over divisor plus one
// (R06) transmit divides tick by 16, 8, 2
// (R07) receive steps 16, 8 or 2 states per bit
// (R08) divisor is twelve bits from two registers
// (R09) bit rate follows divisor and mode factor
// (R10) double speed only affects asynchronous mode
// (R11) double speed receive uses eight samples
// (R12) slave clock synchronized then edge detected
// (R13) external clock below quarter system clock
// (R14) sample on edge opposite to data change
// (R15) polarity zero: change rising, sample falling
// (R16) start, five to nine data, parity, stops
// (R17) start, data lsb first, parity, then stop
// (R18) next frame follows at once or line idles
// (R19) one format shared by transmit and receive
// (R20) only first stop bit checked for error
// (R21) parity is xor of data, odd inverts
// (R22) size code seven selects nine data bits
// (R23) parity codes: 00 off, 10 even, 11 odd
`ifndef USART_CONSTS_SVH
`define USART_CONSTS_SVH
`define REG_DATA       3'h0
`define REG_STATUS_A   3'h1
`define REG_CTRL_B     3'h2
`define REG_CTRL_C     3'h3
`define REG_BAUD_LO    3'h4
`define REG_BAUD_HI    3'h5
`define SA_DOUBLE      0
`define SA_TX_EMPTY    1
`define SA_TX_DONE     2
`define SA_RX_FULL     3
`define SA_FRAME_ERR   4
`define SA_PARITY_ERR  5
`define CB_TX_EN       0
`define CB_RX_EN       1
`define CB_TX_BIT8     2
`define CB_RX_BIT8     3
`define CB_CLK_DIR     4
`define CC_SYNC        0
`define CC_PM          2:1
`define CC_STOP2       3
`define CC_CS          6:4
`define CC_POL         7
`define BAUD_HI_BITS   3:0
`define CTRL_C_RST     8'h30
`define DIVISOR_ZERO   12'h000
`define DIV16_LAST     4'hF
`define DIV8_LAST      4'h7
`define MID16          4'h7
`define MID8           4'h3
`define CS_NINE        3'h7
`define DBITS_BASE     4'h5
`define DBITS_NINE     4'h9
`define MIN_EXT_DIV    12'h002
`endif

// file: usart_pkg.sv
// types and helper functions shared by both link ends
package usart_pkg;
`include "usart_consts.svh"
  typedef enum logic [2:0]
  {
    TX_IDLE   = 3'h0,
    TX_START  = 3'h1,
    TX_DATA   = 3'h3,
    TX_PARITY = 3'h2,
    TX_STOP1  = 3'h6,
    TX_STOP2  = 3'h7
  } tx_state_t;
  typedef enum logic [1:0]
  {
    RX_IDLE   = 2'h0,
    RX_DATA   = 2'h1,
    RX_PARITY = 2'h3,
    RX_STOP   = 2'h2
  } rx_state_t;
  typedef struct packed {
    logic [2:0] char_size;
    logic [1:0] parity_mode;
    logic       stop2;
  } format_t;
  function automatic logic [3:0] data_bits(input logic [2:0] cs);
    return (cs == `CS_NINE) ? `DBITS_NINE : `DBITS_BASE + {2'h0, cs[1:0]};
  endfunction
  function automatic logic parity_bit(input logic [8:0] d,
                                      input logic [3:0] n,
                                      input logic       odd);
    logic p;
    p = odd;
    for (int i = 0; i < 9; i++)
      if (4'(i) < n)
        p = p ^ d[i];
    return p;
  endfunction
endpackage

// file: usart_link_if.sv
// serial link between the device end and the remote end
`timescale 1ns/1ps
interface usart_link_if;
  logic dev_serial_out;
  logic peer_serial_out;
  logic dev_xck_o;
  logic dev_xck_oe;
  logic peer_xck_o;
  logic peer_xck_oe;
  logic xck;
  // undriven clock line floats high through a pull-up
  assign xck = dev_xck_oe ? dev_xck_o : (peer_xck_oe ? peer_xck_o : 1'b1);
  modport device (output dev_serial_out, dev_xck_o, dev_xck_oe,
                  input peer_serial_out, xck);
  modport peer (output peer_serial_out, peer_xck_o, peer_xck_oe,
                input dev_serial_out, xck);
endinterface

// file: frame_engine.sv
// frame shifter for transmit and receive, shared by both ends
`timescale 1ns/1ps
`include "usart_consts.svh"
module frame_engine (
  // clock and reset
  input  wire logic               clock,
  input  wire logic               sys_rst,
  // frame format
  input  wire usart_pkg::format_t fmt,
  // transmit
  input  wire logic               tx_step,
  input  wire logic               load,
  input  wire logic [8:0]         load_data,
  output logic                    tx_ready,
  output logic                    tx_line,
  output logic                    tx_done,
  // receive
  input  wire logic               rx_sample,
  input  wire logic               rx_bit,
  output logic                    rx_busy,
  output logic                    rx_done,
  output logic [8:0]              rx_data,
  output logic                    rx_fe,
  output logic                    rx_pe
);
  typedef struct packed {
    usart_pkg::tx_state_t tx_st;
    logic [8:0]           tx_sh;
    logic [8:0]           buf_d;
    logic                 buf_full;
    logic                 tx_ready;
    logic [3:0]           tx_cnt;
    logic                 tx_par;
    logic                 tx_line;
    logic                 tx_done;
    usart_pkg::rx_state_t rx_st;
    logic [8:0]           rx_sh;
    logic [3:0]           rx_cnt;
    logic                 rx_par;
    logic [8:0]           rx_data;
    logic                 rx_fe;
    logic                 rx_pe;
    logic                 rx_done;
  } eng_state_t;
  eng_state_t st_r;
  eng_state_t st_nxt;
  always_comb
  begin
    logic [3:0] n;
    logic       par_on;
    logic       take;
    logic [8:0] word;
    n = usart_pkg::data_bits(fmt.char_size); // see (R19) (R22)
    par_on = fmt.parity_mode[1]; // see (R23)
    take = 1'b0;
    word = st_r.rx_sh >> (`DBITS_NINE - n);
    st_nxt = st_r;
    st_nxt.tx_done = 1'b0;
    st_nxt.rx_done = 1'b0;
    if (load)
    begin
      st_nxt.buf_d = load_data;
      st_nxt.buf_full = 1'b1;
    end
    if (tx_step)
      case (st_r.tx_st)
        usart_pkg::TX_IDLE: take = st_r.buf_full;
        usart_pkg::TX_START:
        begin
          st_nxt.tx_st = usart_pkg::TX_DATA; // see (R17)
          st_nxt.tx_line = st_r.tx_sh[0];
          st_nxt.tx_sh = st_r.tx_sh >> 1;
          st_nxt.tx_cnt = 4'h1;
        end
        usart_pkg::TX_DATA:
          if (st_r.tx_cnt == n)
          begin
            st_nxt.tx_st = par_on ? usart_pkg::TX_PARITY : usart_pkg::TX_STOP1;
            st_nxt.tx_line = par_on ? st_r.tx_par : 1'b1; // see (R17)
          end
          else
          begin
            st_nxt.tx_line = st_r.tx_sh[0];
            st_nxt.tx_sh = st_r.tx_sh >> 1;
            st_nxt.tx_cnt = st_r.tx_cnt + 4'h1;
          end
        usart_pkg::TX_PARITY:
        begin
          st_nxt.tx_st = usart_pkg::TX_STOP1;
          st_nxt.tx_line = 1'b1;
        end
        usart_pkg::TX_STOP1:
          if (fmt.stop2)
            st_nxt.tx_st = usart_pkg::TX_STOP2; // see (R16)
          else
            take = 1'b1;
        default: take = 1'b1;
      endcase
    if (take && !st_r.buf_full)
    begin
      st_nxt.tx_st = usart_pkg::TX_IDLE; // see (R18)
      st_nxt.tx_line = 1'b1;
      st_nxt.tx_done = (st_r.tx_st != usart_pkg::TX_IDLE);
    end
    else if (take)
    begin
      // back to back frames: the buffer feeds the next start bit
      st_nxt.tx_st = usart_pkg::TX_START; // see (R18)
      st_nxt.tx_line = 1'b0;
      st_nxt.tx_sh = st_r.buf_d;
      st_nxt.tx_par = usart_pkg::parity_bit(st_r.buf_d, n,
                                            fmt.parity_mode[0]); // see (R21)
      st_nxt.buf_full = 1'b0;
    end
    st_nxt.tx_ready = !st_nxt.buf_full;
    if (rx_sample)
      case (st_r.rx_st)
        usart_pkg::RX_IDLE:
          if (!rx_bit)
          begin
            st_nxt.rx_st = usart_pkg::RX_DATA;
            st_nxt.rx_cnt = 4'h0;
          end
        usart_pkg::RX_DATA:
        begin
          st_nxt.rx_sh = {rx_bit, st_r.rx_sh[8:1]}; // see (R17)
          st_nxt.rx_cnt = st_r.rx_cnt + 4'h1;
          if (st_r.rx_cnt + 4'h1 == n)
            st_nxt.rx_st = par_on ? usart_pkg::RX_PARITY : usart_pkg::RX_STOP;
        end
        usart_pkg::RX_PARITY:
        begin
          st_nxt.rx_par = rx_bit;
          st_nxt.rx_st = usart_pkg::RX_STOP;
        end
        default:
        begin
          // a second stop bit is never looked at
          st_nxt.rx_st = usart_pkg::RX_IDLE;
          st_nxt.rx_data = word;
          st_nxt.rx_fe = !rx_bit; // see (R20)
          st_nxt.rx_pe = par_on && (st_r.rx_par != usart_pkg::parity_bit(
                           word, n, fmt.parity_mode[0])); // see (R21)
          st_nxt.rx_done = 1'b1;
        end
      endcase
  end
  always_ff @(posedge clock)
    if (sys_rst)
    begin
      st_r <= '0;
      st_r.tx_line <= 1'b1;
      st_r.tx_ready <= 1'b1;
    end
    else
      st_r <= st_nxt;
  assign tx_ready = st_r.tx_ready;
  assign tx_line = st_r.tx_line;
  assign tx_done = st_r.tx_done;
  assign rx_busy = (st_r.rx_st != usart_pkg::RX_IDLE);
  assign rx_done = st_r.rx_done;
  assign rx_data = st_r.rx_data;
  assign rx_fe = st_r.rx_fe;
  assign rx_pe = st_r.rx_pe;
endmodule

// file: usart_device.sv
// device end: registers, baud generator, clock modes, frame engine
//
// Our own choices: the register addresses and the strobed register port.
`timescale 1ns/1ps
`include "usart_consts.svh"
module usart_device (
  // clock and reset
  input  wire logic         clock,
  input  wire logic         sys_rst,
  // register port
  input  wire logic [2:0]   addr,
  input  wire logic [7:0]   wdata,
  input  wire logic         wr,
  input  wire logic         rd,
  output logic [7:0]        rdata,
  // serial link
  usart_link_if.device      link
);
  typedef struct packed {
    logic [7:0]  rdata;
    logic [7:0]  ctrl_b;
    logic [7:0]  ctrl_c;
    logic        double_speed;
    logic [11:0] divisor;
    logic [11:0] count;
    logic        tick;
    logic [3:0]  tx_pre;
    logic [3:0]  rx_pre;
    logic        rx_run;
    logic        xck_int;
    logic        xck_oe;
    logic        xs1;
    logic        xs2;
    logic        xs3;
    logic        rs1;
    logic        rs2;
    logic        tx_done;
    logic        rx_full;
  } dev_state_t;
  dev_state_t st_r;
  dev_state_t st_nxt;

  usart_pkg::format_t fmt;
  logic       tx_step;
  logic       rx_sample;
  logic       load;
  logic [8:0] load_data;
  logic       tx_ready;
  logic       tx_line;
  logic       eng_tx_done;
  logic       rx_busy;
  logic       rx_done;
  logic [8:0] rx_data;
  logic       rx_fe;
  logic       rx_pe;

  always_comb
  begin
    logic       sync;
    logic       master;
    logic       slave;
    logic       dbl;
    logic [3:0] last;
    logic [3:0] mid;
    logic       pin_rise;
    logic       pin_fall;
    logic       a_step;
    logic       a_samp;
    logic       s_change;
    logic       s_samp;
    logic       lo_wr;
    logic [7:0] sa;
    sync = st_r.ctrl_c[`CC_SYNC]; // see (R01)
    master = sync && st_r.ctrl_b[`CB_CLK_DIR]; // see (R02)
    slave = sync && !st_r.ctrl_b[`CB_CLK_DIR]; // see (R02)
    // software keeps double speed cleared in sync mode; masked anyway
    dbl = st_r.double_speed && !sync; // see (R10)
    last = dbl ? `DIV8_LAST : `DIV16_LAST; // see (R06) (R09)
    mid = dbl ? `MID8 : `MID16; // see (R11)
    lo_wr = wr && (addr == `REG_BAUD_LO);
    pin_rise = 1'b0;
    pin_fall = 1'b0;
    st_nxt = st_r;
    st_nxt.rdata = 8'h00;

    // register writes
    if (wr)
      case (addr)
        `REG_STATUS_A:
        begin
          st_nxt.double_speed = wdata[`SA_DOUBLE];
          if (wdata[`SA_TX_DONE])
            st_nxt.tx_done = 1'b0;
        end
        `REG_CTRL_B: st_nxt.ctrl_b = wdata;
        `REG_CTRL_C: st_nxt.ctrl_c = wdata;
        `REG_BAUD_LO: st_nxt.divisor[7:0] = wdata; // see (R08)
        `REG_BAUD_HI:
          st_nxt.divisor[11:8] = wdata[`BAUD_HI_BITS]; // see (R08)
        default: st_nxt.divisor = st_r.divisor;
      endcase

    // baud generator: tick once per divisor plus one clocks
    st_nxt.tick = (st_r.count == `DIVISOR_ZERO); // see (R05)
    if (st_r.count == `DIVISOR_ZERO || lo_wr)
      st_nxt.count = st_nxt.divisor; // see (R04)
    else
      st_nxt.count = st_r.count - 12'h001; // see (R04)

    // pin synchronizers; first stage feeds only the second
    st_nxt.xs1 = link.xck;
    st_nxt.xs2 = st_r.xs1;
    st_nxt.xs3 = st_r.xs2;
    st_nxt.rs1 = link.peer_serial_out;
    st_nxt.rs2 = st_r.rs1;

    // master: each tick toggles the clock, so bit rate is tick / 2
    if (!master)
      st_nxt.xck_int = 1'b0;
    else if (st_r.tick)
      st_nxt.xck_int = !st_r.xck_int; // see (R06) (R09)
    st_nxt.xck_oe = master; // see (R03)

    if (master)
    begin
      pin_rise = st_r.tick && !st_r.xck_int;
      pin_fall = st_r.tick && st_r.xck_int;
    end
    else
    begin
      // slave edges seen two to three clocks after the pin moves
      pin_rise = slave && st_r.xs2 && !st_r.xs3; // see (R12)
      pin_fall = slave && !st_r.xs2 && st_r.xs3; // see (R12)
    end
    s_change = st_r.ctrl_c[`CC_POL] ? pin_fall : pin_rise; // see (R15)
    s_samp = st_r.ctrl_c[`CC_POL] ? pin_rise : pin_fall; // see (R14) (R15)

    // asynchronous transmit prescaler
    a_step = st_r.tick && (st_r.tx_pre >= last); // see (R06)
    if (st_r.tick)
      st_nxt.tx_pre = (st_r.tx_pre >= last) ? 4'h0 : st_r.tx_pre + 4'h1;

    // asynchronous receive: free-running state count after start edge
    a_samp = st_r.tick && st_r.rx_run && (st_r.rx_pre == mid); // see (R07)
    if (!st_r.rx_run)
    begin
      st_nxt.rx_pre = 4'h0;
      if (st_r.tick && !rx_busy && !st_r.rs2)
        st_nxt.rx_run = 1'b1;
    end
    else if (st_r.tick)
      st_nxt.rx_pre = (st_r.rx_pre >= last) ? 4'h0 : st_r.rx_pre + 4'h1;
    // false start: line back high at the start bit centre
    if (rx_done || (a_samp && !rx_busy && st_r.rs2))
      st_nxt.rx_run = 1'b0;
    if (sync)
      st_nxt.rx_run = 1'b0;

    tx_step = sync ? s_change : a_step; // see (R01)
    rx_sample = st_r.ctrl_b[`CB_RX_EN] && (sync ? s_samp : a_samp);

    // a write while the buffer is occupied is dropped
    load = wr && (addr == `REG_DATA) && tx_ready && st_r.ctrl_b[`CB_TX_EN];
    load_data = {st_r.ctrl_b[`CB_TX_BIT8], wdata}; // see (R22)

    // reads: data read frees the receive slot
    sa = 8'h00;
    sa[`SA_DOUBLE] = st_r.double_speed;
    sa[`SA_TX_EMPTY] = tx_ready;
    sa[`SA_TX_DONE] = st_r.tx_done;
    sa[`SA_RX_FULL] = st_r.rx_full;
    sa[`SA_FRAME_ERR] = rx_fe;
    sa[`SA_PARITY_ERR] = rx_pe;
    if (rd)
      case (addr)
        `REG_DATA:
        begin
          st_nxt.rdata = rx_data[7:0];
          st_nxt.rx_full = 1'b0;
        end
        `REG_STATUS_A: st_nxt.rdata = sa;
        `REG_CTRL_B:
        begin
          st_nxt.rdata = st_r.ctrl_b;
          st_nxt.rdata[`CB_RX_BIT8] = rx_data[8];
        end
        `REG_CTRL_C: st_nxt.rdata = st_r.ctrl_c;
        `REG_BAUD_LO: st_nxt.rdata = st_r.divisor[7:0];
        `REG_BAUD_HI: st_nxt.rdata = {4'h0, st_r.divisor[11:8]};
        default: st_nxt.rdata = 8'h00;
      endcase

    // events win over a clear in the same cycle
    if (eng_tx_done)
      st_nxt.tx_done = 1'b1;
    if (rx_done)
      st_nxt.rx_full = 1'b1;
  end

  always_ff @(posedge clock)
    if (sys_rst)
    begin
      st_r <= '0;
      st_r.ctrl_c <= `CTRL_C_RST;
      st_r.xs1 <= 1'b1;
      st_r.xs2 <= 1'b1;
      st_r.xs3 <= 1'b1;
      st_r.rs1 <= 1'b1;
      st_r.rs2 <= 1'b1;
    end
    else
      st_r <= st_nxt;

  // one format drives both directions
  assign fmt.char_size = st_r.ctrl_c[`CC_CS]; // see (R19)
  assign fmt.parity_mode = st_r.ctrl_c[`CC_PM]; // see (R19)
  assign fmt.stop2 = st_r.ctrl_c[`CC_STOP2]; // see (R19)

  frame_engine engine (
    .clock     (clock),
    .sys_rst   (sys_rst),
    .fmt       (fmt),
    .tx_step   (tx_step),
    .load      (load),
    .load_data (load_data),
    .tx_ready  (tx_ready),
    .tx_line   (tx_line),
    .tx_done   (eng_tx_done),
    .rx_sample (rx_sample),
    .rx_bit    (st_r.rs2),
    .rx_busy   (rx_busy),
    .rx_done   (rx_done),
    .rx_data   (rx_data),
    .rx_fe     (rx_fe),
    .rx_pe     (rx_pe)
  );

  assign rdata = st_r.rdata;
  assign link.dev_serial_out = tx_line;
  assign link.dev_xck_o = st_r.xck_int;
  assign link.dev_xck_oe = st_r.xck_oe; // see (R03)
endmodule

// file: usart_peer.sv
// remote end: same frame format, clocks the link when device is slave
`timescale 1ns/1ps
`include "usart_consts.svh"
module usart_peer (
  // clock and reset
  input  wire logic               clock,
  input  wire logic               sys_rst,
  // configuration
  input  wire logic               sync_mode_select,
  input  wire logic               clock_master,
  input  wire logic               sync_clock_polarity,
  input  wire logic               double_speed,
  input  wire logic [11:0]        baud_divisor,
  input  wire usart_pkg::format_t fmt,
  // transmit stream
  input  wire logic [8:0]         tx_data,
  input  wire logic               tx_valid,
  output logic                    tx_ready,
  // receive stream
  output logic [8:0]              rx_data,
  output logic                    rx_valid,
  output logic                    rx_frame_error,
  output logic                    rx_parity_error,
  // serial link
  usart_link_if.peer              link
);
  typedef struct packed {
    logic [11:0] count;
    logic        tick;
    logic [3:0]  tx_pre;
    logic [3:0]  rx_pre;
    logic        rx_run;
    logic        xck_int;
    logic        xck_oe;
    logic        xs1;
    logic        xs2;
    logic        xs3;
    logic        rs1;
    logic        rs2;
  } peer_state_t;
  peer_state_t st_r;
  peer_state_t st_nxt;
  logic tx_step;
  logic rx_sample;
  logic rx_busy;
  always_comb
  begin
    logic       master;
    logic       dbl;
    logic [3:0] last;
    logic [11:0] div;
    logic       rise;
    logic       fall;
    master = sync_mode_select && clock_master;
    dbl = double_speed && !sync_mode_select; // see (R10)
    last = dbl ? `DIV8_LAST : `DIV16_LAST;
    // driving the device clock: keep it strictly under a quarter rate
    div = (master && baud_divisor < `MIN_EXT_DIV) ? `MIN_EXT_DIV
                                                  : baud_divisor; // see (R13)
    st_nxt = st_r;
    st_nxt.tick = (st_r.count == `DIVISOR_ZERO);
    st_nxt.count = st_nxt.tick ? div : st_r.count - 12'h001;
    st_nxt.xs1 = link.xck;
    st_nxt.xs2 = st_r.xs1;
    st_nxt.xs3 = st_r.xs2;
    st_nxt.rs1 = link.dev_serial_out;
    st_nxt.rs2 = st_r.rs1;
    st_nxt.xck_oe = master;
    st_nxt.xck_int = master && (st_r.tick ? !st_r.xck_int : st_r.xck_int);
    rise = master ? st_r.tick && !st_r.xck_int : st_r.xs2 && !st_r.xs3;
    fall = master ? st_r.tick && st_r.xck_int : !st_r.xs2 && st_r.xs3;
    if (st_r.tick)
      st_nxt.tx_pre = (st_r.tx_pre >= last) ? 4'h0 : st_r.tx_pre + 4'h1;
    if (!st_r.rx_run)
    begin
      st_nxt.rx_pre = 4'h0;
      st_nxt.rx_run = st_r.tick && !rx_busy && !st_r.rs2;
    end
    else if (st_r.tick)
      st_nxt.rx_pre = (st_r.rx_pre >= last) ? 4'h0 : st_r.rx_pre + 4'h1;
    rx_sample = sync_mode_select ?
                (sync_clock_polarity ? rise : fall) : // see (R14) (R15)
                st_r.tick && st_r.rx_run &&
                (st_r.rx_pre == (dbl ? `MID8 : `MID16));
    tx_step = sync_mode_select ? (sync_clock_polarity ? fall : rise)
                               : st_r.tick && (st_r.tx_pre >= last);
    if (rx_valid || (rx_sample && !rx_busy && st_r.rs2) || sync_mode_select)
      st_nxt.rx_run = 1'b0;
  end
  always_ff @(posedge clock)
    if (sys_rst)
    begin
      st_r <= '0;
      st_r.xs1 <= 1'b1;
      st_r.xs2 <= 1'b1;
      st_r.xs3 <= 1'b1;
      st_r.rs1 <= 1'b1;
      st_r.rs2 <= 1'b1;
    end
    else
      st_r <= st_nxt;
  frame_engine engine (
    .clock     (clock),
    .sys_rst   (sys_rst),
    .fmt       (fmt), // see (R16)
    .tx_step   (tx_step),
    .load      (tx_valid && tx_ready),
    .load_data (tx_data),
    .tx_ready  (tx_ready),
    .tx_line   (link.peer_serial_out), // see (R17) (R18)
    .tx_done   (),
    .rx_sample (rx_sample),
    .rx_bit    (st_r.rs2),
    .rx_busy   (rx_busy),
    .rx_done   (rx_valid),
    .rx_data   (rx_data),
    .rx_fe     (rx_frame_error),
    .rx_pe     (rx_parity_error)
  );
  assign link.peer_xck_o = st_r.xck_int;
  assign link.peer_xck_oe = st_r.xck_oe;
endmodule

// file: usart_link_sva.sv
// link checker: reset idle, transfer clock shape, bit spacing
`timescale 1ns/1ps
module usart_link_sva (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // link signals
  input wire logic dev_serial_out,
  input wire logic peer_serial_out,
  input wire logic dev_xck_o,
  input wire logic dev_xck_oe,
  input wire logic peer_xck_o,
  input wire logic peer_xck_oe,
  input wire logic xck
);
  // figures assume the bench divisor of 2: a tick every 3 clocks
  logic       dprev_r;
  logic       pprev_r;
  logic       xprev_r;
  logic [5:0] dgap_r;
  logic [5:0] pgap_r;
  logic [3:0] egap_r;
  logic       dchg;
  logic       pchg;
  assign dchg = dev_serial_out != dprev_r;
  assign pchg = peer_serial_out != pprev_r;
  always_ff @(posedge clock)
  begin
    dprev_r <= dev_serial_out;
    pprev_r <= peer_serial_out;
    xprev_r <= xck;
    if (sys_rst)
    begin
      dgap_r <= 6'h3F;
      pgap_r <= 6'h3F;
      egap_r <= 4'hF;
    end
    else
    begin
      dgap_r <= dchg ? 6'h01 : dgap_r + {5'h00, dgap_r != 6'h3F};
      pgap_r <= pchg ? 6'h01 : pgap_r + {5'h00, pgap_r != 6'h3F};
      egap_r <= (xck != xprev_r) ? 4'h1 : egap_r + {3'h0, egap_r != 4'hF};
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  sequence s_xck_high;
    dev_xck_o [*3] ##1 !dev_xck_o;
  endsequence
  a_reset_idle: assert property (disable iff (1'b0) sys_rst |=>
    dev_serial_out && peer_serial_out && !dev_xck_oe && !peer_xck_oe)
    else $error("link not idle after reset");
  a_one_driver: assert property (!(dev_xck_oe && peer_xck_oe))
    else $error("both ends drive the clock pin");
  // a clock cut by leaving master mode is not a short phase
  a_master_high: assert property (
    disable iff (sys_rst || !dev_xck_oe)
    $rose(dev_xck_o) |-> s_xck_high)
    else $error("master clock high phase wrong");
  a_master_low: assert property ($fell(dev_xck_o) && dev_xck_oe
    |-> !dev_xck_o [*3]) else $error("master clock low phase short");
  a_peer_quarter: assert property (
    disable iff (sys_rst || !peer_xck_oe)
    $rose(peer_xck_o) |-> peer_xck_o [*2])
    else $error("external clock too fast");
  a_dev_bit_gap: assert property (dchg |-> dgap_r >= 6'h06)
    else $error("device bit shorter than a bit time");
  a_peer_bit_gap: assert property (pchg |-> pgap_r >= 6'h06)
    else $error("remote bit shorter than a bit time");
  a_edge_follow: assert property ((dev_xck_oe || peer_xck_oe)
    && dchg |-> egap_r <= 4'h5)
    else $error("sync data change not tied to clock");
endmodule

// file: usart_clock_and_frame_format_tb.sv
// testbench: device and remote end joined over the serial link
`timescale 1ns/1ps
module usart_clock_and_frame_format_tb;
  typedef struct packed {
    logic [3:0] mode;
    logic [2:0] cs;
    logic [1:0] pm;
    logic       st2;
    logic [8:0] d;
    logic [8:0] e;
  } row_t;
  // mode bits: sync, device master, polarity, double speed
  row_t rows [9] = '{
    '{4'h0, 3'h3, 2'h0, 1'h0, 9'h0A5, 9'h0A5},
    '{4'h1, 3'h0, 2'h2, 1'h1, 9'h1F3, 9'h013},
    '{4'h0, 3'h1, 2'h3, 1'h0, 9'h02D, 9'h02D},
    '{4'h1, 3'h2, 2'h1, 1'h1, 9'h155, 9'h055},
    '{4'h0, 3'h7, 2'h2, 1'h0, 9'h1C3, 9'h1C3},
    '{4'hC, 3'h3, 2'h3, 1'h0, 9'h03C, 9'h03C},
    '{4'hE, 3'h7, 2'h0, 1'h1, 9'h1A5, 9'h1A5},
    '{4'h8, 3'h2, 2'h2, 1'h0, 9'h06B, 9'h06B},
    '{4'hA, 3'h1, 2'h0, 1'h1, 9'h012, 9'h012}};
  logic               clock = 1'b0;
  logic               sys_rst = 1'b1;
  logic [2:0]         addr = 3'h0;
  logic [7:0]         wdata = 8'h00;
  logic               wr = 1'b0;
  logic               rd = 1'b0;
  logic [7:0]         rdata;
  logic               p_sync = 1'b0;
  logic               p_master = 1'b0;
  logic               p_pol = 1'b0;
  logic               p_dbl = 1'b0;
  usart_pkg::format_t p_fmt = 6'h18;
  logic [8:0]         p_tx_data = 9'h000;
  logic               p_tx_valid = 1'b0;
  logic               p_tx_ready;
  logic [8:0]         p_rx_data;
  logic               p_rx_valid;
  logic               p_fe;
  logic               p_pe;
  logic [7:0]         s;
  int                 num_errors = 0;
  int                 samples_checked = 0;
  usart_link_if link ();
  usart_device usart_device_i (.clock(clock), .sys_rst(sys_rst),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .link(link));
  usart_peer usart_peer_i (.clock(clock), .sys_rst(sys_rst),
    .sync_mode_select(p_sync), .clock_master(p_master),
    .sync_clock_polarity(p_pol), .double_speed(p_dbl),
    .baud_divisor(12'h002), .fmt(p_fmt), .tx_data(p_tx_data),
    .tx_valid(p_tx_valid), .tx_ready(p_tx_ready), .rx_data(p_rx_data),
    .rx_valid(p_rx_valid), .rx_frame_error(p_fe),
    .rx_parity_error(p_pe), .link(link));
  usart_link_sva usart_link_sva_i (.clock(clock), .sys_rst(sys_rst),
    .dev_serial_out(link.dev_serial_out),
    .peer_serial_out(link.peer_serial_out), .dev_xck_o(link.dev_xck_o),
    .dev_xck_oe(link.dev_xck_oe), .peer_xck_o(link.peer_xck_o),
    .peer_xck_oe(link.peer_xck_oe), .xck(link.xck));
  always #2 clock = ~clock;
  task automatic conclude;
    if (num_errors == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [10:0] seen, input logic [10:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clock);
    wr    <= 1'b0;
  endtask
  task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
    @(posedge clock);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clock);
    rd   <= 1'b0;
    @(negedge clock);
    d = rdata;
  endtask
  task automatic psend(input logic [8:0] d);
    @(posedge clock);
    p_tx_data  <= d;
    p_tx_valid <= 1'b1;
    do @(posedge clock); while (p_tx_ready !== 1'b1);
    p_tx_valid <= 1'b0;
  endtask
  task automatic run(input row_t r, input usart_pkg::format_t pf,
                     input logic [1:0] est, input logic dtx);
    logic [8:0] m;
    logic [7:0] st;
    logic [7:0] cb;
    logic [7:0] lo;
    int         n;
    // let the previous frame's stop bits finish before reformatting
    repeat (120) @(posedge clock);
    m = (r.cs == 3'h7) ? 9'h1FF : 9'h1FF >> (3'h4 - {1'b0, r.cs[1:0]});
    // free the clock pin before the far end may drive it
    wr_reg(3'h2, 8'h00);
    p_sync   <= r.mode[3];
    p_master <= r.mode[3] & ~r.mode[2];
    p_pol    <= r.mode[1];
    p_dbl    <= r.mode[0];
    p_fmt    <= pf;
    wr_reg(3'h5, 8'h00);
    wr_reg(3'h4, 8'h02);
    wr_reg(3'h1, {7'h00, r.mode[0]});
    wr_reg(3'h3, {r.mode[1], r.cs, r.st2, r.pm, r.mode[3]});
    wr_reg(3'h2, {3'h0, r.mode[2], 1'b0, r.d[8], 2'h3});
    if (r.mode[3:2] == 2'h3)
      psend(r.d);
    if (dtx)
      wr_reg(3'h0, r.d[7:0]);
    if (r.mode[3:2] != 2'h3)
      psend(r.d);
    fork
      if (dtx)
      begin
        n = 0;
        while (p_rx_valid !== 1'b1 && n < 4000)
        begin
          @(negedge clock);
          n++;
        end
        if (n >= 4000)
          num_errors++;
        chk({p_pe, p_fe, p_rx_data & m}, {est, r.e});
      end
      begin
        do rd_reg(3'h1, st); while (st[3] !== 1'b1 && st[1] !== 1'bx);
        rd_reg(3'h2, cb);
        rd_reg(3'h0, lo);
        chk({st[5:4], {cb[3], lo} & m}, {est, r.e});
      end
    join
  endtask
  initial
  begin
    repeat (40000) @(posedge clock);
    num_errors++;
    conclude();
  end
  initial
  begin
    repeat (16) @(posedge clock);
    sys_rst <= 1'b0;
    rd_reg(3'h3, s);
    chk({3'h0, s}, 11'h030);
    rd_reg(3'h7, s);
    chk({3'h0, s}, 11'h000);
    for (int i = 0; i < 9; i++)
      run(rows[i], {rows[i].cs, rows[i].pm, rows[i].st2}, 2'h0, 1'b1);
    run('{4'h0, 3'h3, 2'h3, 1'h0, 9'h001, 9'h001}, 6'h1C, 2'h2, 1'b0);
    run('{4'h0, 3'h0, 2'h0, 1'h0, 9'h003, 9'h003}, 6'h04, 2'h1, 1'b0);
    conclude();
  end
endmodule
